/* sim/acrb_i2c_master.sv */
// Two-wire bus master model that drives the register bank pins
`timescale 1ns/1ns
`default_nettype none
module acrb_i2c_master (
  output var  logic scl_out,     // Bus clock, idles high
  output var  logic sda_drv_out, // Data drive, 1 = released
  input  wire logic sda_in       // Resolved data wire
);
  initial {scl_out, sda_drv_out} = 2'b11;
  // Data moves mid low phase, well clear of the sync delay
  task automatic put_bit(input logic b);
    #31 sda_drv_out = b;
    #31 scl_out = 1'b1;
    #63 scl_out = 1'b0;
  endtask
  task automatic get_bit(output logic b);
    #31 sda_drv_out = 1'b1;
    #31 scl_out = 1'b1;
    #31 b = sda_in;
    #32 scl_out = 1'b0;
  endtask
  // Also serves as repeated start
  task automatic start_cond;
    #31 sda_drv_out = 1'b1;
    #31 scl_out = 1'b1;
    #31 sda_drv_out = 1'b0;
    #32 scl_out = 1'b0;
  endtask
  task automatic stop_cond;
    #31 sda_drv_out = 1'b0;
    #31 scl_out = 1'b1;
    #63 sda_drv_out = 1'b1;
    #125;
  endtask
  task automatic tx_byte(input logic [7:0] d, output logic nak);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(nak);
  endtask
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] a, d,
                           output logic [2:0] nak);
    start_cond;
    tx_byte({dev, 1'b0}, nak[2]);
    tx_byte(a, nak[1]);
    tx_byte(d, nak[0]);
    stop_cond;
  endtask
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] a,
                          output logic [7:0] d, output logic [2:0] nak);
    start_cond;
    tx_byte({dev, 1'b0}, nak[2]);
    tx_byte(a, nak[1]);
    start_cond;
    tx_byte({dev, 1'b1}, nak[0]);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(1'b1);
    stop_cond;
  endtask
endmodule // acrb_i2c_master
`default_nettype wire

/* sim/tb_acrb_top.sv */
// Self-checking bench for the amplifier control register bank
`timescale 1ns/1ns
`default_nettype none
module tb_acrb_top;
  localparam logic [7:0] ID_VAL = 8'h3C; // Arbitrary value
  localparam logic [6:0] DEV    = 7'h6C; // Strap held low
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        en = 1'b1;
  logic [3:0]  ev = 4'h0;
  wire         scl, sda_drv, sda_wire;
  logic        sda_o, sda_oe_n, slp, sdn, pse, lvs, dpd, ppd, fade, mr, ml;
  logic [19:0] clip;
  logic [7:0]  dpath, vl, vr, ost;
  logic [1:0]  oct;
  logic [7:0]  exp_reg [0:255];
  logic [7:0]  ofs [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
                            8'h06, 8'h07, 8'h08, 8'h10, 8'h11, 8'h20};
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          seed = 32'h5ef5;
  always #4 clk = ~clk;
  assign sda_wire = sda_drv & (sda_oe_n | sda_o); // Pulled up when free
  acrb_top #(.ID_CODE(ID_VAL)) i_acrb_top (
    .ref_clk_in(clk), .nrst_in(nrst), .clk_en_in(en), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
    .addr_sel_in(1'b0), .overcurrent_in(ev[2]), .clock_fault_in(ev[3]),
    .dc_offset_in(ev[1]), .overtemp_in(ev[0]), .clip_threshold_out(clip),
    .sleep_out(slp), .speaker_shutdown_n_out(sdn),
    .power_stage_en_out(pse), .lowv_standby_out(lvs),
    .digital_pd_out(dpd), .power_stage_pd_out(ppd),
    .digital_path_out(dpath), .fade_en_out(fade), .mute_right_out(mr),
    .mute_left_out(ml), .volume_left_out(vl), .volume_right_out(vr),
    .output_stage_out(ost), .oc_threshold_out(oct));
  acrb_i2c_master i_acrb_i2c_master (.scl_out(scl), .sda_drv_out(sda_drv),
    .sda_in(sda_wire));
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_reg(input string n, input logic [7:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_out(input string n, input logic [63:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic mdl_write(input logic [7:0] a, d);
    logic [7:0] m;
    case (a)
      8'h01, 8'h04, 8'h05, 8'h10: m = acrb_pkg::WM_FULL;
      8'h02: m = acrb_pkg::WM_DIG_PATH;
      8'h03: m = acrb_pkg::WM_VOL_FADE;
      8'h06: m = acrb_pkg::WM_OUT_STAGE;
      8'h08: m = acrb_pkg::WM_FAULT_CFG;
      8'h11: m = acrb_pkg::WM_CLIP_LOW;
      default: m = 8'h00;
    endcase
    exp_reg[a] = (exp_reg[a] & ~m) | (d & m);
    if (a == 8'h08) exp_reg[a][3:0] = exp_reg[a][3:0] & ~d[3:0];
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [2:0] nk;
    i_acrb_i2c_master.write_reg(DEV, a, d, nk);
    chk_reg("write acks", 8'h00, {5'h00, nk});
    mdl_write(a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    logic [7:0] d;
    logic [2:0] nk;
    i_acrb_i2c_master.read_reg(DEV, a, d, nk);
    chk_reg("read acks", 8'h00, {5'h00, nk});
    chk_reg("register", exp_reg[a], d);
  endtask
  task automatic chk_pins;
    logic [7:0]  p;
    logic [36:0] su;
    p = exp_reg[1];
    su = {exp_reg[2], exp_reg[3][7], exp_reg[3][1:0], exp_reg[4],
          exp_reg[5], exp_reg[6], exp_reg[8][5:4]};
    chk_out("clip", 64'({p[7:2], exp_reg[16], exp_reg[17][7:2]}),
            64'(clip));
    chk_out("power", 64'({p[1], p[0], p[0] & ~p[1], p[0] & p[1], ~p[0],
            ~p[0]}), 64'({slp, sdn, pse, lvs, dpd, ppd}));
    chk_out("setup", 64'(su),
            64'({dpath, fade, mr, ml, vl, vr, ost, oct}));
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      n_mismatch++;
      end_of_test;
    end
  end
  initial begin
    logic [2:0] nk;
    exp_reg = '{default: 8'h00};
    exp_reg[0] = ID_VAL;
    exp_reg[1] = 8'hFD;
    exp_reg[2] = 8'h14;
    exp_reg[3] = 8'h80;
    exp_reg[4] = 8'hCF;
    exp_reg[5] = 8'hCF;
    exp_reg[6] = 8'h51;
    exp_reg[16] = 8'hFF;
    exp_reg[17] = 8'hFC;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    repeat (8) @(negedge clk);
    chk_pins;
    foreach (ofs[i]) rd(ofs[i]);
    $display("test reset_values done");
    foreach (ofs[i]) begin
      wr(ofs[i], 8'($random(seed)));
      rd(ofs[i]);
      chk_pins;
    end
    $display("test write_read done");
    for (int k = 0; k < 4; k++) begin
      wr(8'h01, {6'($random(seed)), 2'(k)});
      chk_pins;
    end
    $display("test power_modes done");
    i_acrb_i2c_master.write_reg(7'h6D, 8'h04, 8'h00, nk);
    chk_reg("foreign acks", 8'h07, {5'h00, nk});
    rd(8'h04);
    $display("test foreign_address done");
    for (int b = 0; b < 4; b++) begin
      @(negedge clk);
      ev[b] = 1'b1;
      @(negedge clk);
      ev[b] = 1'b0;
      exp_reg[8][b] = 1'b1;
      rd(8'h08);
      wr(8'h08, 8'(1 << b));
      rd(8'h08);
    end
    $display("test fault_flags done");
    // Event while the enable is low must leave the flags frozen
    @(negedge clk);
    {en, ev[0]} = 2'b01;
    @(negedge clk);
    {en, ev[0]} = 2'b10;
    rd(8'h08);
    $display("test clock_enable done");
    end_of_test;
  end
endmodule // tb_acrb_top
`default_nettype wire

/* src/acrb_bus_cond.sv */
// Clock edge and start/stop detection on the synchronised serial bus
`timescale 1ns/1ns
`default_nettype none
module acrb_bus_cond (
  input  wire logic ref_clk_in, // Core clock
  input  wire logic nrst_in,    // Async reset, active low
  input  wire logic clk_en_in,  // Clock enable
  input  wire logic scl_in,     // Synchronised bus clock
  input  wire logic sda_in,     // Synchronised bus data
  output var  logic rise_out,   // Bus clock rising edge pulse
  output var  logic fall_out,   // Bus clock falling edge pulse
  output var  logic start_out,  // Start or repeated start pulse
  output var  logic stop_out    // Stop pulse
);
  logic scl_prev_reg;
  logic scl_prev_next;
  logic sda_prev_reg;
  logic sda_prev_next;

  always_comb begin
    scl_prev_next = scl_in;
    sda_prev_next = sda_in;
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else if (clk_en_in) begin
      scl_prev_reg <= scl_prev_next;
      sda_prev_reg <= sda_prev_next;
    end
  end

  // Data moving while the clock stays high marks start or stop
  assign rise_out  = clk_en_in & scl_in & ~scl_prev_reg;
  assign fall_out  = clk_en_in & ~scl_in & scl_prev_reg;
  assign start_out = clk_en_in & scl_in & scl_prev_reg & sda_prev_reg
                     & ~sda_in;
  assign stop_out  = clk_en_in & scl_in & scl_prev_reg & ~sda_prev_reg
                     & sda_in;
endmodule // acrb_bus_cond
`default_nettype wire

/* src/acrb_pkg.sv */
// Constants and types shared by the amplifier control register bank
`default_nettype none
package acrb_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PART_ID    = 8'h00;
  localparam logic [7:0] OFS_PWR_CLIP   = 8'h01;
  localparam logic [7:0] OFS_DIG_PATH   = 8'h02;
  localparam logic [7:0] OFS_VOL_FADE   = 8'h03;
  localparam logic [7:0] OFS_VOL_LEFT   = 8'h04;
  localparam logic [7:0] OFS_VOL_RIGHT  = 8'h05;
  localparam logic [7:0] OFS_OUT_STAGE  = 8'h06;
  localparam logic [7:0] OFS_UNUSED_7   = 8'h07;
  localparam logic [7:0] OFS_FAULT      = 8'h08;
  localparam logic [7:0] OFS_CLIP_MID   = 8'h10;
  localparam logic [7:0] OFS_CLIP_LOW   = 8'h11;
  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_PWR_CLIP   = 8'hFD;
  localparam logic [7:0] RST_DIG_PATH   = 8'h14;
  localparam logic [7:0] RST_VOL_FADE   = 8'h80;
  localparam logic [7:0] RST_VOL_LEVEL  = 8'hCF;
  localparam logic [7:0] RST_OUT_STAGE  = 8'h51;
  localparam logic [7:0] RST_RESERVED   = 8'h00;
  localparam logic [7:0] RST_FAULT      = 8'h00;
  localparam logic [7:0] RST_CLIP_MID   = 8'hFF;
  localparam logic [7:0] RST_CLIP_LOW   = 8'hFC;
  // ----------------------------------------------------------------
  // Writable bit masks; other bits keep their reset value, except the fault flags in bits 3:0
  // ----------------------------------------------------------------
  localparam logic [7:0] WM_FULL        = 8'hFF;
  localparam logic [7:0] WM_DIG_PATH    = 8'hBF;
  localparam logic [7:0] WM_VOL_FADE    = 8'h83;
  localparam logic [7:0] WM_OUT_STAGE   = 8'hFE;
  localparam logic [7:0] WM_FAULT_CFG   = 8'h30;
  localparam logic [7:0] WM_CLIP_LOW    = 8'hFC;
  // ----------------------------------------------------------------
  // Field positions, device address and byte length
  // ----------------------------------------------------------------
  localparam int         POS_SLEEP      = 1;
  localparam int         POS_SHUTDOWN_N = 0;
  localparam logic [5:0] DEV_ADDR_HIGH  = 6'h36;
  localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
  // ----------------------------------------------------------------
  // Serial slave states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_MASTER_ACK
  } acrb_state_t;
endpackage
`default_nettype wire

/* src/acrb_sync.sv */
// Two-stage synchroniser for pins entering the core clock domain
`timescale 1ns/1ns
`default_nettype none
module acrb_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk_in, // Core clock
  input  wire logic             nrst_in,    // Async reset, active low
  input  wire logic             clk_en_in,  // Clock enable
  input  wire logic [WIDTH-1:0] async_in,   // Pins from outside
  output var  logic [WIDTH-1:0] sync_out    // Synchronised levels
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  // Idle bus level is high, so both stages reset to ones
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else if (clk_en_in) begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule // acrb_sync
`default_nettype wire

/* src/acrb_top.sv */
// Amplifier control register bank behind a two-wire serial slave
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// RQ1: Read-only fixed identification byte at zero
// RQ2: Threshold top six bits from power bits
// RQ3: Threshold middle at 0x10, low at 0x11
// RQ4: Sleep bit disables the power stage
// RQ5: Sleep keeps low-voltage blocks on standby
// RQ6: Shutdown bit zero is active low
// RQ7: Shutdown powers down both supply domains
// RQ8: Write: address, register, data, each acknowledged
// RQ9: Read: register, repeated start, data, nack
// RQ10: Reserved offsets and bits keep defaults
module acrb_top #(
  parameter logic [7:0] ID_CODE = 8'hA5 // Arbitrary value
) (
  input  wire logic        ref_clk_in,        // Core clock, 125 MHz
  input  wire logic        nrst_in,           // Async reset, active low
  input  wire logic        clk_en_in,         // Freezes all state when low
  input  wire logic        scl_in,            // Serial bus clock pin
  input  wire logic        sda_in,            // Serial bus data pin
  output var  logic        sda_out,           // Data pin drive level
  output var  logic        sda_oe_n_out,      // Data pin drive, active low
  input  wire logic        addr_sel_in,       // Address select strap
  input  wire logic        overcurrent_in,    // Overcurrent event
  input  wire logic        clock_fault_in,    // Clock error event
  input  wire logic        dc_offset_in,      // DC offset event
  input  wire logic        overtemp_in,       // Overtemperature event
  output var  logic [19:0] clip_threshold_out,// Digital clip threshold
  output var  logic        sleep_out,         // Sleep mode
  output var  logic        speaker_shutdown_n_out, // Shutdown, low active
  output var  logic        power_stage_en_out,// Power stage enabled
  output var  logic        lowv_standby_out,  // Low-voltage standby
  output var  logic        digital_pd_out,    // Digital domain down
  output var  logic        power_stage_pd_out,// Power stage domain down
  output var  logic [7:0]  digital_path_out,  // Digital path setup
  output var  logic        fade_en_out,       // Volume fade enable
  output var  logic        mute_right_out,    // Right channel mute
  output var  logic        mute_left_out,     // Left channel mute
  output var  logic [7:0]  volume_left_out,   // Left volume level
  output var  logic [7:0]  volume_right_out,  // Right volume level
  output var  logic [7:0]  output_stage_out,  // Output stage setup
  output var  logic [1:0]  oc_threshold_out   // Overcurrent threshold
);
  // ----------------------------------------------------------------
  // Pin synchronisation and bus conditions
  // ----------------------------------------------------------------
  logic [2:0] pins_sync;
  logic       scl_s;
  logic       sda_s;
  logic       addr_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;

  acrb_sync #(.WIDTH(3)) u_sync (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .clk_en_in  (clk_en_in),
    .async_in   ({scl_in, sda_in, addr_sel_in}),
    .sync_out   (pins_sync)
  );
  assign scl_s  = pins_sync[2];
  assign sda_s  = pins_sync[1];
  assign addr_s = pins_sync[0];

  acrb_bus_cond u_cond (
    .ref_clk_in (ref_clk_in),
    .nrst_in    (nrst_in),
    .clk_en_in  (clk_en_in),
    .scl_in     (scl_s),
    .sda_in     (sda_s),
    .rise_out   (scl_rise),
    .fall_out   (scl_fall),
    .start_out  (bus_start),
    .stop_out   (bus_stop)
  );

  // ----------------------------------------------------------------
  // Serial slave state machine
  // ----------------------------------------------------------------
  acrb_pkg::acrb_state_t state_reg;
  acrb_pkg::acrb_state_t state_next;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic [7:0] shift_reg;
  logic [7:0] shift_next;
  logic [7:0] tx_reg;
  logic [7:0] tx_next;
  logic [7:0] ptr_reg;
  logic [7:0] ptr_next;
  logic       drive_reg;
  logic       drive_next;
  logic       strap_done_reg;
  logic       strap_done_next;
  logic       strap_reg;
  logic       strap_next;
  logic [1:0] strap_age_reg;
  logic [1:0] strap_age_next;
  logic       wr_en;
  logic [7:0] rd_data;

  always_comb begin
    state_next      = state_reg;
    cnt_next        = cnt_reg;
    shift_next      = shift_reg;
    tx_next         = tx_reg;
    ptr_next        = ptr_reg;
    drive_next      = drive_reg;
    wr_en           = 1'b0;
    strap_age_next  = {strap_age_reg[0], 1'b1};
    strap_done_next = strap_done_reg | strap_age_reg[1];
    // Strap caught once the synchroniser has flushed its reset ones
    strap_next      = (strap_done_reg || !strap_age_reg[1]) ? strap_reg
                                                            : addr_s;
    if (bus_start) begin
      state_next = acrb_pkg::ST_ADDR;
      cnt_next   = 4'h0;
      drive_next = 1'b0;
    end else if (bus_stop) begin
      state_next = acrb_pkg::ST_IDLE;
      drive_next = 1'b0;
    end else if (scl_rise && state_reg != acrb_pkg::ST_IDLE) begin
      shift_next = {shift_reg[6:0], sda_s};
      cnt_next   = cnt_reg + 4'h1;
    end else if (scl_fall) begin
      case (state_reg)
        acrb_pkg::ST_ADDR: begin
          if (cnt_reg == acrb_pkg::BITS_PER_BYTE) begin
            if (shift_reg[7:1] == {acrb_pkg::DEV_ADDR_HIGH, strap_reg})
            begin
              state_next = acrb_pkg::ST_ADDR_ACK; // RQ8
              drive_next = 1'b1;
            end else begin
              state_next = acrb_pkg::ST_IDLE;
            end
          end
        end
        acrb_pkg::ST_ADDR_ACK: begin
          cnt_next = 4'h0;
          // Direction bit sits one place up once the ack bit shifted in
          if (shift_reg[1]) begin
            state_next = acrb_pkg::ST_RDATA; // RQ9
            tx_next    = rd_data;
            drive_next = ~rd_data[7];
          end else begin
            state_next = acrb_pkg::ST_REG;
            drive_next = 1'b0;
          end
        end
        acrb_pkg::ST_REG: begin
          if (cnt_reg == acrb_pkg::BITS_PER_BYTE) begin
            ptr_next   = shift_reg;
            state_next = acrb_pkg::ST_REG_ACK; // RQ8
            drive_next = 1'b1;
          end
        end
        acrb_pkg::ST_WDATA: begin
          if (cnt_reg == acrb_pkg::BITS_PER_BYTE) begin
            wr_en      = 1'b1; // RQ8
            ptr_next   = ptr_reg + 8'h01;
            state_next = acrb_pkg::ST_WDATA_ACK;
            drive_next = 1'b1;
          end
        end
        acrb_pkg::ST_REG_ACK, acrb_pkg::ST_WDATA_ACK: begin
          state_next = acrb_pkg::ST_WDATA;
          cnt_next   = 4'h0;
          drive_next = 1'b0;
        end
        acrb_pkg::ST_RDATA: begin
          if (cnt_reg == acrb_pkg::BITS_PER_BYTE) begin
            // Release so the master can answer
            state_next = acrb_pkg::ST_MASTER_ACK; // RQ9
            ptr_next   = ptr_reg + 8'h01;
            drive_next = 1'b0;
          end else begin
            tx_next    = {tx_reg[6:0], 1'b1};
            drive_next = ~tx_reg[6];
          end
        end
        acrb_pkg::ST_MASTER_ACK: begin
          cnt_next = 4'h0;
          if (!shift_reg[0]) begin
            state_next = acrb_pkg::ST_RDATA;
            tx_next    = rd_data;
            drive_next = ~rd_data[7];
          end else begin
            // Not-acknowledge: stay off the bus until the stop
            state_next = acrb_pkg::ST_IDLE; // RQ9
          end
        end
        default: state_next = acrb_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg      <= acrb_pkg::ST_IDLE;
      cnt_reg        <= 4'h0;
      shift_reg      <= 8'h00;
      tx_reg         <= 8'h00;
      ptr_reg        <= 8'h00;
      drive_reg      <= 1'b0;
      strap_done_reg <= 1'b0;
      strap_reg      <= 1'b0;
      strap_age_reg  <= 2'b00;
    end else if (clk_en_in) begin
      state_reg      <= state_next;
      cnt_reg        <= cnt_next;
      shift_reg      <= shift_next;
      tx_reg         <= tx_next;
      ptr_reg        <= ptr_next;
      drive_reg      <= drive_next;
      strap_done_reg <= strap_done_next;
      strap_reg      <= strap_next;
      strap_age_reg  <= strap_age_next;
    end
  end

  // Open drain: only ever pulls low
  assign sda_out      = 1'b0;
  assign sda_oe_n_out = ~drive_reg;

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] pwr_reg, pwr_next;
  logic [7:0] dig_reg, dig_next;
  logic [7:0] vcfg_reg, vcfg_next;
  logic [7:0] voll_reg, voll_next;
  logic [7:0] volr_reg, volr_next;
  logic [7:0] ana_reg, ana_next;
  logic [7:0] flt_reg, flt_next;
  logic [7:0] cmid_reg, cmid_next;
  logic [7:0] clow_reg, clow_next;
  logic [3:0] flt_events;

  assign flt_events = {clock_fault_in, overcurrent_in, dc_offset_in,
                       overtemp_in};

  always_comb begin
    pwr_next  = pwr_reg;
    dig_next  = dig_reg;
    vcfg_next = vcfg_reg;
    voll_next = voll_reg;
    volr_next = volr_reg;
    ana_next  = ana_reg;
    cmid_next = cmid_reg;
    clow_next = clow_reg;
    // Events are sticky; a set in the clearing cycle wins
    flt_next  = {flt_reg[7:4], flt_reg[3:0] | flt_events};
    if (wr_en) begin
      case (ptr_reg)
        acrb_pkg::OFS_PWR_CLIP:  pwr_next  = shift_reg; // RQ2 RQ4 RQ6
        acrb_pkg::OFS_DIG_PATH:  dig_next  =
          (shift_reg & acrb_pkg::WM_DIG_PATH) |
          (acrb_pkg::RST_DIG_PATH & ~acrb_pkg::WM_DIG_PATH); // RQ10
        acrb_pkg::OFS_VOL_FADE:  vcfg_next =
          (shift_reg & acrb_pkg::WM_VOL_FADE) |
          (acrb_pkg::RST_VOL_FADE & ~acrb_pkg::WM_VOL_FADE); // RQ10
        acrb_pkg::OFS_VOL_LEFT:  voll_next = shift_reg;
        acrb_pkg::OFS_VOL_RIGHT: volr_next = shift_reg;
        acrb_pkg::OFS_OUT_STAGE: ana_next  =
          (shift_reg & acrb_pkg::WM_OUT_STAGE) |
          (acrb_pkg::RST_OUT_STAGE & ~acrb_pkg::WM_OUT_STAGE); // RQ10
        acrb_pkg::OFS_FAULT: begin
          // Status flags clear by writing one
          flt_next[7:4] = shift_reg[7:4] & acrb_pkg::WM_FAULT_CFG[7:4];
          flt_next[3:0] = (flt_reg[3:0] & ~shift_reg[3:0]) | flt_events;
        end
        acrb_pkg::OFS_CLIP_MID:  cmid_next = shift_reg; // RQ3
        acrb_pkg::OFS_CLIP_LOW:  clow_next =
          shift_reg & acrb_pkg::WM_CLIP_LOW; // RQ3
        default: ; // RQ1 RQ10
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pwr_reg  <= acrb_pkg::RST_PWR_CLIP;
      dig_reg  <= acrb_pkg::RST_DIG_PATH;
      vcfg_reg <= acrb_pkg::RST_VOL_FADE;
      voll_reg <= acrb_pkg::RST_VOL_LEVEL;
      volr_reg <= acrb_pkg::RST_VOL_LEVEL;
      ana_reg  <= acrb_pkg::RST_OUT_STAGE;
      flt_reg  <= acrb_pkg::RST_FAULT;
      cmid_reg <= acrb_pkg::RST_CLIP_MID;
      clow_reg <= acrb_pkg::RST_CLIP_LOW;
    end else if (clk_en_in) begin
      pwr_reg  <= pwr_next;
      dig_reg  <= dig_next;
      vcfg_reg <= vcfg_next;
      voll_reg <= voll_next;
      volr_reg <= volr_next;
      ana_reg  <= ana_next;
      flt_reg  <= flt_next;
      cmid_reg <= cmid_next;
      clow_reg <= clow_next;
    end
  end

  always_comb begin
    case (ptr_reg)
      acrb_pkg::OFS_PART_ID:   rd_data = ID_CODE; // RQ1
      acrb_pkg::OFS_PWR_CLIP:  rd_data = pwr_reg;
      acrb_pkg::OFS_DIG_PATH:  rd_data = dig_reg;
      acrb_pkg::OFS_VOL_FADE:  rd_data = vcfg_reg;
      acrb_pkg::OFS_VOL_LEFT:  rd_data = voll_reg;
      acrb_pkg::OFS_VOL_RIGHT: rd_data = volr_reg;
      acrb_pkg::OFS_OUT_STAGE: rd_data = ana_reg;
      acrb_pkg::OFS_FAULT:     rd_data = flt_reg;
      acrb_pkg::OFS_CLIP_MID:  rd_data = cmid_reg;
      acrb_pkg::OFS_CLIP_LOW:  rd_data = clow_reg;
      default:                 rd_data = acrb_pkg::RST_RESERVED; // RQ10
    endcase
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  assign clip_threshold_out = {pwr_reg[7:2], cmid_reg, clow_reg[7:2]};
  assign sleep_out              = pwr_reg[acrb_pkg::POS_SLEEP];
  assign speaker_shutdown_n_out = pwr_reg[acrb_pkg::POS_SHUTDOWN_N];
  // Shutdown outranks sleep: nothing stays on standby when shut down
  assign power_stage_en_out = speaker_shutdown_n_out & ~sleep_out; // RQ4
  assign lowv_standby_out   = speaker_shutdown_n_out & sleep_out;  // RQ5
  assign digital_pd_out     = ~speaker_shutdown_n_out;             // RQ7
  assign power_stage_pd_out = ~speaker_shutdown_n_out;             // RQ7
  assign digital_path_out   = dig_reg;
  assign fade_en_out        = vcfg_reg[7];
  assign mute_right_out     = vcfg_reg[1];
  assign mute_left_out      = vcfg_reg[0];
  assign volume_left_out    = voll_reg;
  assign volume_right_out   = volr_reg;
  assign output_stage_out   = ana_reg;
  assign oc_threshold_out   = flt_reg[5:4];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);

  property p_id_fixed;
    (ptr_reg == acrb_pkg::OFS_PART_ID) |-> (rd_data == ID_CODE);
  endproperty
  a_id_fixed: assert property (p_id_fixed) // RQ1
    else $error("identification byte changed");

  property p_clip_high;
    (wr_en && clk_en_in && ptr_reg == acrb_pkg::OFS_PWR_CLIP) |=>
      clip_threshold_out[19:14] == $past(shift_reg[7:2]);
  endproperty
  a_clip_high: assert property (p_clip_high) // RQ2
    else $error("threshold high bits not from power register");

  property p_clip_mid;
    (wr_en && clk_en_in && ptr_reg == acrb_pkg::OFS_CLIP_MID) |=>
      clip_threshold_out[13:6] == $past(shift_reg);
  endproperty
  a_clip_mid: assert property (p_clip_mid) // RQ3
    else $error("threshold middle bits wrong");

  property p_sleep_stage;
    sleep_out |-> !power_stage_en_out;
  endproperty
  a_sleep_stage: assert property (p_sleep_stage) // RQ4
    else $error("power stage enabled in sleep");

  property p_standby;
    (sleep_out && speaker_shutdown_n_out) |->
      (lowv_standby_out && !digital_pd_out);
  endproperty
  a_standby: assert property (p_standby) // RQ5
    else $error("low-voltage blocks not on standby in sleep");

  property p_shutdown_low;
    (wr_en && clk_en_in && ptr_reg == acrb_pkg::OFS_PWR_CLIP &&
     !shift_reg[0]) |=> !speaker_shutdown_n_out ##0 !power_stage_en_out;
  endproperty
  a_shutdown_low: assert property (p_shutdown_low) // RQ6
    else $error("writing zero did not shut down");

  property p_both_domains;
    !speaker_shutdown_n_out |-> (digital_pd_out && power_stage_pd_out);
  endproperty
  a_both_domains: assert property (p_both_domains) // RQ7
    else $error("shutdown left a domain powered");

  property p_write_ack;
    (wr_en && clk_en_in) |=> !sda_oe_n_out;
  endproperty
  a_write_ack: assert property (p_write_ack) // RQ8
    else $error("data byte not acknowledged");

  property p_read_release;
    (state_reg == acrb_pkg::ST_MASTER_ACK) |-> sda_oe_n_out;
  endproperty
  a_read_release: assert property (p_read_release) // RQ9
    else $error("data pin driven in master answer slot");

  property p_reserved_bit;
    (wr_en && clk_en_in && ptr_reg == acrb_pkg::OFS_DIG_PATH) |=>
      digital_path_out[6] == acrb_pkg::RST_DIG_PATH[6];
  endproperty
  a_reserved_bit: assert property (p_reserved_bit) // RQ10
    else $error("reserved bit changed by write");

  c_pwr_write: cover property (wr_en && ptr_reg == acrb_pkg::OFS_PWR_CLIP);
  c_read_byte: cover property (state_reg == acrb_pkg::ST_MASTER_ACK);
  c_sleep: cover property ($rose(sleep_out));
endmodule // acrb_top
`default_nettype wire
